// ===== hw/sio_sram_port.sv
// Synchronous port of a separate-I/O double-data-rate SRAM, write path first.
// Assumes control and data pins are synchronous to i_clk (positive input clock);
// the word sampled on the negative input clock arrives on its own port.
`timescale 1ns/1ns
`default_nettype none

module sio_sram_port
    import sio_sram_pkg::*;
#(
    parameter int ADDR_W          = 10,
    parameter int PLL_LOCK_CNT    = PLL_LOCK_CYCLES,
    parameter int IMP_PERIOD      = IMP_UPDATE_CYCLES,
    parameter int FIFO_DEPTH      = WR_FIFO_DEPTH
) (
    input  wire logic                i_clk,
    input  wire logic                i_nrst,
    input  wire logic                i_load_strobe_n,
    input  wire logic                i_rw,
    input  wire logic [ADDR_W-1:0]   i_addr,
    input  wire logic [WORD_W-1:0]   i_d_rise,
    input  wire logic [WORD_W-1:0]   i_d_fall,
    input  wire logic [LANES-1:0]    i_byte_lane_select_n,
    input  wire logic [LANES-1:0]    i_byte_lane_select_late_n,
    input  wire logic                i_out_clk_p,
    input  wire logic                i_out_clk_n,
    input  wire logic                i_k_pin,
    input  wire logic                i_pll_disable_n,
    input  wire logic                i_impedance_ref_pin,
    output var  logic [WORD_W-1:0]   o_q_fall,
    output var  logic [WORD_W-1:0]   o_q_rise,
    output var  logic                o_q_oe_n,
    output var  logic                o_echo_ref_pos,
    output var  logic                o_echo_ref_neg,
    output var  logic                o_single_clock,
    output var  logic                o_pll_locked,
    output var  logic                o_legacy_mode,
    output var  logic                o_imp_update,
    output var  logic                o_imp_level,
    output var  logic                o_wr_ready
);
    localparam int ENTRY_W = ADDR_W + BURST_W + 2 * LANES;
    localparam int LW      = $clog2(FIFO_DEPTH + 1);
    localparam int PW      = $clog2(PLL_LOCK_CNT + 1);
    localparam int IW      = $clog2(IMP_PERIOD);
    localparam int SW      = $clog2(CLK_STALL_CYCLES + 1);

    // Array as two 9-bit lanes for each of the two burst words
    logic [LANE_W-1:0] array_q [2**ADDR_W][2*LANES];

    // Synchronisers for asynchronous pins
    logic [2:0] sync_cp_q;
    logic [2:0] sync_cn_q;
    logic [2:0] sync_k_q;
    logic [2:0] sync_pd_q;
    logic [2:0] sync_imp_q;
    logic [2:0] fill_q;

    // Command decode
    cmd_t              cmd;
    wire               wr_cmd;
    wire               rd_cmd;
    wire               wr_take;

    // Write pipeline
    logic              wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    wire  [ENTRY_W-1:0] wr_entry;
    wire  [2*LANES-1:0] wr_lane_en;

    // FIFO drain side
    wire               fifo_in_ready;
    wire               fifo_out_valid;
    wire  [ENTRY_W-1:0] fifo_out_data;
    wire  [LW-1:0]     fifo_level;
    wire               drain;
    wire  [ADDR_W-1:0] drain_addr;
    wire  [BURST_W-1:0] drain_data;
    wire  [2*LANES-1:0] drain_en;

    // Read pipeline
    logic              rd_prev_q;
    logic [WORD_W-1:0] rd_hi_q;
    wire  [WORD_W-1:0] rd_lo_word;
    wire  [WORD_W-1:0] rd_hi_word;

    // Straps, clocks and housekeeping
    logic              strap_taken_q;
    logic              single_clk_q;
    logic              k_div_q;
    logic [SW-1:0]     stall_cnt_q;
    wire               k_edge;
    wire               k_stalled;
    logic [PW-1:0]     lock_cnt_q;
    logic [IW-1:0]     imp_cnt_q;
    wire               echo_src;
    wire               legacy;

    // Output flops
    logic [WORD_W-1:0] q_fall_q;
    logic [WORD_W-1:0] q_rise_q;
    logic              q_oe_n_q;
    logic              echo_pos_q;
    logic              echo_neg_q;
    logic              pll_locked_q;
    logic              legacy_q;
    logic              imp_update_q;
    logic              imp_level_q;
    logic              wr_ready_q;

    // Command decode from load strobe and read/write select
    always_comb begin
        if (i_load_strobe_n) begin
            cmd = CMD_NOP;
        end else if (i_rw) begin
            cmd = CMD_READ;
        end else begin
            cmd = CMD_WRITE;
        end
    end

    assign wr_cmd  = (cmd == CMD_WRITE);
    assign rd_cmd  = (cmd == CMD_READ);
    // A command may follow a command each cycle while room remains
    assign wr_take = wr_cmd && (fifo_level + LW'(wr_pend_q) < LW'(FIFO_DEPTH));

    // Lane enables: each word carries its own active-low selects
    assign wr_lane_en = {~i_byte_lane_select_late_n, ~i_byte_lane_select_n};
    assign wr_entry   = {wr_addr_q, i_d_fall, i_d_rise, wr_lane_en};

    // Command capture; once deselected only the pending burst completes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= wr_take;
            if (wr_take) begin
                wr_addr_q <= i_addr;
            end
        end
    end

    // Posted-write buffer between the input registers and the array
    sio_wr_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk       (i_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (wr_pend_q),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (wr_entry),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (drain),
        .o_out_data  (fifo_out_data),
        .o_level     (fifo_level)
    );

    // The newest burst stays posted until the next write command arrives
    assign drain      = fifo_out_valid && (wr_cmd || (fifo_level > LW'(1)));
    assign drain_addr = fifo_out_data[ENTRY_W-1 -: ADDR_W];
    assign drain_data = fifo_out_data[2*LANES +: BURST_W];
    assign drain_en   = fifo_out_data[2*LANES-1:0];

    // Commit both words of a burst in one step, lane by lane
    always_ff @(posedge i_clk) begin
        if (drain) begin
            for (int ln = 0; ln < 2 * LANES; ln++) begin
                if (drain_en[ln]) begin
                    array_q[drain_addr][ln] <= drain_data[ln*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Read words at the command address
    assign rd_lo_word = {array_q[i_addr][1], array_q[i_addr][0]};
    assign rd_hi_word = {array_q[i_addr][3], array_q[i_addr][2]};

    // Read pipeline: low word for cycle t+1, high word for cycle t+2
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_prev_q <= 1'b0;
            rd_hi_q   <= '0;
            q_fall_q  <= '0;
            q_rise_q  <= '0;
            q_oe_n_q  <= RST_OE_N;
        end else begin
            rd_prev_q <= rd_cmd;
            if (rd_cmd) begin
                q_fall_q <= rd_lo_word;
                rd_hi_q  <= rd_hi_word;
            end
            if (rd_prev_q) begin
                q_rise_q <= rd_hi_q;
            end
            // Driven only while a burst is on the bus, released after it
            q_oe_n_q <= !(rd_cmd || rd_prev_q);
        end
    end

    // Three-stage synchronisers on asynchronous pins
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_cp_q <= RST_SYNC;
            sync_cn_q <= RST_SYNC;
            sync_k_q  <= RST_SYNC;
            sync_pd_q <= RST_SYNC;
            sync_imp_q <= RST_SYNC;
            fill_q    <= RST_SYNC;
        end else begin
            sync_cp_q <= {sync_cp_q[1:0], i_out_clk_p};
            sync_cn_q <= {sync_cn_q[1:0], i_out_clk_n};
            sync_k_q  <= {sync_k_q[1:0], i_k_pin};
            sync_pd_q <= {sync_pd_q[1:0], i_pll_disable_n};
            sync_imp_q <= {sync_imp_q[1:0], i_impedance_ref_pin};
            // Marks when every stage holds a real pin sample, not a reset value
            fill_q     <= {fill_q[1:0], 1'b1};
        end
    end

    // Strap capture once the synchronisers have filled after reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            strap_taken_q <= 1'b0;
            single_clk_q  <= RST_STRAP;
        end else if (!strap_taken_q && fill_q[2] && (sync_cp_q[1] == sync_cp_q[2])
                     && (sync_cn_q[1] == sync_cn_q[2])) begin
            strap_taken_q <= 1'b1;
            single_clk_q  <= sync_cp_q[2] && sync_cn_q[2];
        end
    end

    // Echo clocks from the input clock or from the output clock pin
    assign echo_src = single_clk_q ? k_div_q : sync_cp_q[2];

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            k_div_q    <= 1'b0;
            echo_pos_q <= 1'b0;
            echo_neg_q <= 1'b1;
        end else begin
            k_div_q    <= !k_div_q;
            echo_pos_q <= echo_src;
            echo_neg_q <= !echo_src;
        end
    end

    // Input clock stall detection on the sampled clock pin
    assign k_edge    = (sync_k_q[1] != sync_k_q[2]);
    assign k_stalled = (stall_cnt_q >= SW'(CLK_STALL_CYCLES));

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stall_cnt_q <= '0;
        end else if (k_edge) begin
            stall_cnt_q <= '0;
        end else if (!k_stalled) begin
            stall_cnt_q <= stall_cnt_q + SW'(1);
        end
    end

    // PLL lock timer; a stall or the disable pin restarts it
    assign legacy = (fill_q[2] && sync_pd_q[1] == sync_pd_q[2]) ? !sync_pd_q[2] : legacy_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lock_cnt_q   <= '0;
            pll_locked_q <= 1'b0;
            legacy_q     <= 1'b0;
        end else begin
            legacy_q <= legacy;
            if (legacy || k_stalled) begin
                lock_cnt_q   <= '0;
                pll_locked_q <= 1'b0;
            end else if (lock_cnt_q < PW'(PLL_LOCK_CNT)) begin
                lock_cnt_q   <= lock_cnt_q + PW'(1);
                pll_locked_q <= 1'b0;
            end else begin
                pll_locked_q <= 1'b1;
            end
        end
    end

    // Impedance re-evaluation every fixed number of cycles from reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            imp_cnt_q    <= '0;
            imp_update_q <= 1'b0;
            imp_level_q  <= 1'b0;
        end else begin
            imp_cnt_q    <= (imp_cnt_q == IW'(IMP_PERIOD - 1)) ? '0 : imp_cnt_q + IW'(1);
            imp_update_q <= (imp_cnt_q == IW'(IMP_PERIOD - 1));
            if (imp_cnt_q == IW'(IMP_PERIOD - 1) && sync_imp_q[1] == sync_imp_q[2]) begin
                imp_level_q <= sync_imp_q[2];
            end
        end
    end

    // Write-ready shows room for another burst behind those in flight
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ready_q <= 1'b0;
        end else begin
            wr_ready_q <= fifo_in_ready && (fifo_level + LW'(wr_take) + LW'(wr_pend_q) < LW'(FIFO_DEPTH));
        end
    end

    // Outputs straight from flops; they hold whenever the clock stops
    assign o_q_fall       = q_fall_q;
    assign o_q_rise       = q_rise_q;
    assign o_q_oe_n       = q_oe_n_q;
    assign o_echo_ref_pos = echo_pos_q;
    assign o_echo_ref_neg = echo_neg_q;
    assign o_single_clock = single_clk_q;
    assign o_pll_locked   = pll_locked_q;
    assign o_legacy_mode  = legacy_q;
    assign o_imp_update   = imp_update_q;
    assign o_imp_level    = imp_level_q;
    assign o_wr_ready     = wr_ready_q;

endmodule

`default_nettype wire

// ===== hw/sio_sram_pkg.sv
// Shared constants for the separate-I/O double-data-rate SRAM port model.
// Assumes one core clock at 250 MHz standing in for the positive input clock.
package sio_sram_pkg;

    // Core clock period in picoseconds
    localparam int CLK_PERIOD_PS      = 4000;

    // Data word and burst layout
    localparam int WORD_W             = 18;
    localparam int LANE_W             = 9;
    localparam int LANES              = 2;
    localparam int BURST_W            = 2 * WORD_W;
    localparam int LANE0_LSB          = 0;
    localparam int LANE1_LSB          = 9;

    // Posted-write buffer depth
    localparam int WR_FIFO_DEPTH      = 32;

    // Output driver impedance update cadence, in clock cycles
    localparam int IMP_UPDATE_CYCLES  = 1024;

    // PLL lock time after stable clock, in microseconds
    localparam int PLL_LOCK_US        = 20;
    localparam int PLL_LOCK_CYCLES    = (PLL_LOCK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Input clock stall that resets the PLL, in nanoseconds (least time, rounded up)
    localparam int CLK_STALL_NS       = 30;
    localparam int CLK_STALL_CYCLES   = (CLK_STALL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Reset values
    localparam logic RST_OE_N         = 1'b1;
    localparam logic RST_STRAP        = 1'b0;
    localparam logic [2:0] RST_SYNC   = 3'h0;

    // Command decode on load strobe and read/write select
    typedef enum logic [2:0] {
        CMD_NOP   = 3'b001,
        CMD_WRITE = 3'b010,
        CMD_READ  = 3'b100
    } cmd_t;

endpackage

// ===== hw/sio_wr_fifo.sv
// Synchronous FIFO holding posted write bursts ahead of the array.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ns
`default_nettype none

module sio_wr_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_nrst,
    input  wire logic                       i_in_valid,
    output var  logic                       o_in_ready,
    input  wire logic [WIDTH-1:0]           i_in_data,
    output var  logic                       o_out_valid,
    input  wire logic                       i_out_ready,
    output var  logic [WIDTH-1:0]           o_out_data,
    output var  logic [$clog2(DEPTH+1)-1:0] o_level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [LW-1:0]    level_q;
    logic [WIDTH-1:0] head_q;
    logic             head_valid_q;
    wire              push;
    wire              pop;
    wire              refill;
    wire  [AW-1:0]    rptr_next;

    // Storage count excludes the registered head word
    assign o_in_ready  = (level_q < LW'(DEPTH));
    assign o_out_valid = head_valid_q;
    assign o_out_data  = head_q;
    assign o_level     = level_q + LW'(head_valid_q);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = head_valid_q && i_out_ready;
    assign refill      = (level_q != '0) && (!head_valid_q || pop);
    assign rptr_next   = (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + AW'(1);

    // Storage array write port
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wptr_q] <= i_in_data;
        end
    end

    // Pointers, level and the registered head word
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wptr_q       <= '0;
            rptr_q       <= '0;
            level_q      <= '0;
            head_q       <= '0;
            head_valid_q <= 1'b0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + AW'(1);
            end
            if (refill) begin
                head_q <= mem_q[rptr_q];
                rptr_q <= rptr_next;
            end
            head_valid_q <= refill ? 1'b1 : (pop ? 1'b0 : head_valid_q);
            level_q      <= level_q + LW'(push) - LW'(refill);
        end
    end

endmodule

`default_nettype wire

// ===== dv/sio_sram_port_assertions.sv
// Timing checks on the pins of the SRAM port model.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module sio_sram_port_chk
    import sio_sram_pkg::*;
#(
    parameter int PLL_LOCK_CNT = 20,
    parameter int IMP_PERIOD   = 16
) (
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_load_strobe_n,
    input  wire logic              i_rw,
    input  wire logic              i_k_pin,
    input  wire logic              i_pll_disable_n,
    input  wire logic [WORD_W-1:0] o_q_fall,
    input  wire logic [WORD_W-1:0] o_q_rise,
    input  wire logic              o_q_oe_n,
    input  wire logic              o_echo_ref_pos,
    input  wire logic              o_echo_ref_neg,
    input  wire logic              o_single_clock,
    input  wire logic              o_pll_locked,
    input  wire logic              o_legacy_mode,
    input  wire logic              o_imp_update
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    logic [15:0] up_q;
    logic [15:0] imp_q;
    logic [4:0]  kc_q;
    logic        k_q;
    logic        seen_q;
    wire         rd = !i_load_strobe_n && i_rw;
    // Cycles since reset, since the last update, and of a still input clock
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            up_q <= 16'h0;
            imp_q <= 16'h0;
            kc_q <= 5'h0;
            k_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            up_q <= (up_q == 16'hffff) ? up_q : up_q + 16'h1;
            imp_q <= o_imp_update ? 16'h0 : imp_q + 16'h1;
            seen_q <= seen_q | o_imp_update;
            k_q <= i_k_pin;
            kc_q <= (i_k_pin != k_q) ? 5'h0 : ((kc_q == 5'h1f) ? kc_q : kc_q + 5'h1);
        end
    end
    property p_rd_oe;
        rd |=> !o_q_oe_n ##1 !o_q_oe_n;
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read enable window wrong");
    property p_hiz;
        !rd ##1 !rd |=> o_q_oe_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("outputs driven while idle");
    property p_fall_hold;
        !rd |=> $stable(o_q_fall);
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("first word changed");
    property p_rise_hold;
        !rd |-> ##2 $stable(o_q_rise);
    endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("second word changed");
    property p_echo_comp;
        o_echo_ref_neg == !o_echo_ref_pos;
    endproperty
    a_echo_comp: assert property (p_echo_comp) else $error("echo pair not complementary");
    property p_echo_run;
        o_single_clock [*3] |-> o_echo_ref_pos != $past(o_echo_ref_pos);
    endproperty
    a_echo_run: assert property (p_echo_run) else $error("echo clock not running");
    property p_imp;
        seen_q |-> (o_imp_update == (imp_q == IMP_PERIOD - 1));
    endproperty
    a_imp: assert property (p_imp) else $error("impedance update cadence wrong");
    property p_lock_time;
        up_q < PLL_LOCK_CNT |-> !o_pll_locked;
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("lock too early");
    property p_stall;
        kc_q == 5'h10 |-> !o_pll_locked;
    endproperty
    a_stall: assert property (p_stall) else $error("lock kept on stalled clock");
    property p_bypass;
        !i_pll_disable_n [*6] |-> o_legacy_mode && !o_pll_locked;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not entered");
endmodule
bind sio_sram_port sio_sram_port_chk #(
    .PLL_LOCK_CNT(PLL_LOCK_CNT),
    .IMP_PERIOD(IMP_PERIOD)
) u_chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_load_strobe_n(i_load_strobe_n), .i_rw(i_rw),
    .i_k_pin(i_k_pin), .i_pll_disable_n(i_pll_disable_n), .o_q_fall(o_q_fall),
    .o_q_rise(o_q_rise), .o_q_oe_n(o_q_oe_n), .o_echo_ref_pos(o_echo_ref_pos),
    .o_echo_ref_neg(o_echo_ref_neg), .o_single_clock(o_single_clock),
    .o_pll_locked(o_pll_locked), .o_legacy_mode(o_legacy_mode), .o_imp_update(o_imp_update)
);
`default_nettype wire

// ===== dv/sio_ctrl_model.sv
// Memory controller model: command, address and pipelined write data.
// Assumes the bench calls step once a cycle; data trail their write by one edge.
`timescale 1ns/1ns
`default_nettype none
module sio_ctrl_model
    import sio_sram_pkg::*;
(
    input  wire logic              i_clk,
    output var  logic              o_load_n,
    output var  logic              o_rw,
    output var  logic [9:0]        o_addr,
    output var  logic [WORD_W-1:0] o_d_rise,
    output var  logic [WORD_W-1:0] o_d_fall,
    output var  logic [1:0]        o_sel_n,
    output var  logic [1:0]        o_sel_late_n
);
    logic [BURST_W-1:0] pd = '0;
    logic [3:0]         ps = 4'h0;
    logic               pw = 1'b0;
    initial begin
        o_load_n = 1'b1;
        o_rw = 1'b0;
        o_addr = 10'h0;
        o_d_rise = '0;
        o_d_fall = '0;
        o_sel_n = 2'h3;
        o_sel_late_n = 2'h3;
    end
    // One cycle: a new command, plus the data of the write before it
    task automatic step(input cmd_t op, input logic [9:0] a, input logic [BURST_W-1:0] d,
                        input logic [3:0] s);
        @(posedge i_clk);
        o_load_n <= (op == CMD_NOP);
        o_rw <= (op == CMD_NOP) ? ~o_rw : (op == CMD_READ);
        o_addr <= (op == CMD_NOP) ? ~o_addr : a;
        if (pw) begin
            o_d_rise <= pd[WORD_W-1:0];
            o_d_fall <= pd[BURST_W-1:WORD_W];
            o_sel_n <= ps[1:0];
            o_sel_late_n <= ps[3:2];
        end else begin
            // Outside a data cycle the lines show the inverse of their last value
            o_d_rise <= ~o_d_rise;
            o_d_fall <= ~o_d_fall;
            o_sel_n <= ~o_sel_n;
            o_sel_late_n <= ~o_sel_late_n;
        end
        pw = (op == CMD_WRITE);
        pd = d;
        ps = s;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_sio_sram_port.sv
// Self-checking bench for the SRAM port model with a controller model.
// Assumes shortened lock and impedance counts; output clocks strapped high, then low.
`timescale 1ns/1ns
`default_nettype none
module tb_sio_sram_port;
    import sio_sram_pkg::*;
    logic                clk;
    logic                nrst;
    logic                k_pin = 1'b0;
    logic                k_run, pll_n, pll_nx, imp_pin, imp_nx, oc;
    logic                load_n, rw, oe_n, ep, en, sgl, lck, leg, upd, lvl, rdy;
    logic [9:0]          addr, pa;
    logic [WORD_W-1:0]   dr, df, qf, qr;
    logic [1:0]          s0, s1;
    logic [WORD_W-1:0]   a0 [1024];
    logic [WORD_W-1:0]   a1 [1024];
    logic [BURST_W-1:0]  pd;
    logic [3:0]          ps;
    logic                pv;
    cmd_t                h [2];
    logic [WORD_W-1:0]   e0;
    logic [WORD_W-1:0]   e1 [2];
    logic [31:0]         seed;
    int                  fails, num_checks;
    sio_ctrl_model ctrl (.i_clk(clk), .o_load_n(load_n), .o_rw(rw), .o_addr(addr), .o_d_rise(dr),
        .o_d_fall(df), .o_sel_n(s0), .o_sel_late_n(s1));
    sio_sram_port #(.PLL_LOCK_CNT(20), .IMP_PERIOD(16)) DUT (
        .i_clk(clk), .i_nrst(nrst), .i_load_strobe_n(load_n), .i_rw(rw), .i_addr(addr),
        .i_d_rise(dr), .i_d_fall(df), .i_byte_lane_select_n(s0), .i_byte_lane_select_late_n(s1),
        .i_out_clk_p(oc), .i_out_clk_n(oc), .i_k_pin(k_pin), .i_pll_disable_n(pll_n),
        .i_impedance_ref_pin(imp_pin), .o_q_fall(qf), .o_q_rise(qr), .o_q_oe_n(oe_n),
        .o_echo_ref_pos(ep), .o_echo_ref_neg(en), .o_single_clock(sgl), .o_pll_locked(lck),
        .o_legacy_mode(leg), .o_imp_update(upd), .o_imp_level(lvl), .o_wr_ready(rdy));
    // Clock and the pins that change outside the command stream
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        k_pin <= k_run ? ~k_pin : k_pin;
        pll_n <= pll_nx;
        imp_pin <= imp_nx;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [BURST_W-1:0] r36();
        logic [63:0] r;
        r = {xs(), xs()};
        return r[BURST_W-1:0];
    endfunction
    // Lane-masked update of one stored word
    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o, input logic [WORD_W-1:0] n,
                                                input logic [1:0] s);
        merge = o;
        if (!s[0]) merge[LANE_W-1:0] = n[LANE_W-1:0];
        if (!s[1]) merge[WORD_W-1:LANE_W] = n[WORD_W-1:LANE_W];
    endfunction
    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({17'h0, got}, {17'h0, exp});
    endtask
    task automatic results;
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One cycle of traffic; the posted burst reaches the model array at the next write
    task automatic go(input cmd_t op, input logic [9:0] a, input logic [BURST_W-1:0] d, input logic [3:0] s);
        if (op == CMD_WRITE && pv) begin
            a0[pa] = merge(a0[pa], pd[WORD_W-1:0], ps[1:0]);
            a1[pa] = merge(a1[pa], pd[BURST_W-1:WORD_W], ps[3:2]);
        end
        if (op == CMD_WRITE) begin
            pv = 1'b1;
            pa = a;
            pd = d;
            ps = s;
            chk1(rdy, 1'b1);
        end
        ctrl.step(op, a, d, s);
        #1;
        // The last command was taken at this edge; the one before it now shows its second word
        if (h[0] == CMD_READ) chk(qf, e0);
        if (h[1] == CMD_READ) chk(qr, e1[1]);
        chk1(oe_n, !(h[0] == CMD_READ || h[1] == CMD_READ));
        h[1] = h[0];
        e1[1] = e1[0];
        h[0] = op;
        e0 = a0[a];
        e1[0] = a1[a];
    endtask
    task automatic idle(input int n);
        repeat (n) go(CMD_NOP, 10'h0, '0, 4'h0);
    endtask
    initial begin
        seed = 32'h0f4e;
        fails = 0;
        num_checks = 0;
        nrst = 1'b0;
        k_run = 1'b1;
        pll_nx = 1'b1;
        imp_nx = 1'b0;
        oc = 1'b1;
        pv = 1'b0;
        for (int i = 0; i < 2; i++) h[i] = CMD_NOP;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // Let the write-ready flag settle before the first write
        idle(2);
        // Full bursts back to back, then every lane-select pairing over them
        for (int i = 0; i < 16; i++) go(CMD_WRITE, 10'(i), r36(), 4'h0);
        for (int i = 0; i < 16; i++) go(CMD_WRITE, 10'(i), r36(), 4'(i));
        go(CMD_WRITE, 10'h3ff, r36(), 4'hf);
        idle(3);
        for (int i = 0; i < 16; i++) go(CMD_READ, 10'(i), '0, 4'h0);
        idle(3);
        // A posted burst stays out of the array until the next write
        go(CMD_WRITE, 10'h5, r36(), 4'h0);
        idle(2);
        go(CMD_READ, 10'h5, '0, 4'h0);
        go(CMD_NOP, 10'h0, '0, 4'h0);
        go(CMD_WRITE, 10'h3ff, r36(), 4'hf);
        idle(2);
        go(CMD_READ, 10'h5, '0, 4'h0);
        idle(3);
        chk1(sgl, 1'b1);
        chk1(en, ~ep);
        chk1(lck, 1'b1);
        // Stalled input clock drops lock; a running one regains it
        k_run = 1'b0;
        idle(18);
        chk1(lck, 1'b0);
        k_run = 1'b1;
        idle(40);
        chk1(lck, 1'b1);
        // Bypass mode keeps the read timing
        pll_nx = 1'b0;
        idle(8);
        chk1(leg, 1'b1);
        chk1(lck, 1'b0);
        go(CMD_READ, 10'h2, '0, 4'h0);
        idle(3);
        pll_nx = 1'b1;
        void'(xs());
        imp_nx = ~seed[0];
        idle(40);
        chk1(lvl, imp_nx);
        imp_nx = ~imp_nx;
        idle(40);
        chk1(lvl, imp_nx);
        // Output clock pins low across a second reset select the two-clock mode
        oc <= 1'b0;
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        idle(8);
        chk1(sgl, 1'b0);
        chk1(ep, 1'b0);
        chk1(en, 1'b1);
        results();
    end
    initial begin
        #20000;
        fails++;
        results();
    end
endmodule
`default_nettype wire
